// *** hdl/ass_pkg.sv ***
// Behaviour
// - a terminal acts as analog source select when its function code is 16
// - with combination 00, select asserted takes the frequency command from the voltage input
// - with combination 00, select deasserted takes the frequency command from the current input
// - selection matters only when the frequency source is the analog terminal set
// - combination 00 voltage/current, 03 pot/current, others pot/voltage (on/off)
// - a reset request through the trip reset input cancels the trip state
// - the trip clears once the reset input has been held on for the minimum width (12 ms), before it is released
// - the alarm output clears no later than 30 ms after the reset input asserts
// - an active run command raises the restart flag as the alarm clears, with the reset input still held; the motor runs once it is released
// - function code 18: while asserted motor off, trip cleared once held for the minimum width, power-up reset on release after that
package ass_pkg;

    // ------------------------------------------------------------
    // terminal layout and function codes
    // ------------------------------------------------------------
    localparam int          NUM_TERM       = 7;
    localparam int          FUNC_W         = 8;
    localparam logic [7:0]  FUNC_ANALOG_SEL = 8'h10;
    localparam logic [7:0]  FUNC_TRIP_RST  = 8'h12;
    localparam logic [7:0]  FREQ_SRC_ANALOG = 8'h01;
    localparam logic [7:0]  COMB_VOLT_CURR = 8'h00;
    localparam logic [7:0]  COMB_POT_CURR  = 8'h03;
    localparam int          ANA_W          = 10;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ          = 200;
    localparam int RS_MIN_WIDTH_US  = 12000;
    localparam int ALARM_CLR_MAX_US = 30000;
    localparam int RS_MIN_CYC       = RS_MIN_WIDTH_US * CLK_MHZ;
    localparam int ALARM_CLR_MAX_CYC = ALARM_CLR_MAX_US * CLK_MHZ;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [ANA_W-1:0] FREQ_RST = 10'h000;

    typedef enum logic [1:0] {
        SRC_VOLT,
        SRC_CURR,
        SRC_POT
    } ass_src_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_HOLD,
        ST_ARMED
    } ass_rst_st_t;

endpackage

// *** hdl/ass_pulse_width.sv ***
`timescale 1ns/1ps
module ass_pulse_width
    import ass_pkg::*;
#(
    parameter int MIN_CYC = RS_MIN_CYC
) (
    // clock and reset
    input  wire logic sys_clk_i,
    input  wire logic rstn_i,
    input  wire logic en_i,
    // level under test
    input  wire logic level_i,
    output logic      met_o
);

    localparam int CW = $clog2(MIN_CYC + 1);
    // met on the sample that completes the minimum width
    localparam logic [CW-1:0] CNT_MIN = CW'(MIN_CYC - 1);

    logic [CW-1:0] cnt_ff;
    logic [CW-1:0] nxt_cnt;
    wire           at_min;

    // ------------------------------------------------------------
    // saturating high-time counter
    // ------------------------------------------------------------
    assign at_min  = (cnt_ff == CNT_MIN);
    assign nxt_cnt = !level_i ? '0 : (at_min ? cnt_ff : cnt_ff + CW'(1));
    assign met_o   = at_min & level_i;

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_ff <= '0;
        end else if (en_i) begin
            cnt_ff <= nxt_cnt;
        end
    end

endmodule

// *** hdl/ass_top.sv ***
`timescale 1ns/1ps
module ass_top
    import ass_pkg::*;
#(
    parameter int MIN_PULSE_CYC = RS_MIN_CYC,
    parameter int N_TERM        = NUM_TERM
) (
    // clock, reset, enable
    input  wire logic                     sys_clk_i,
    input  wire logic                     rstn_i,
    input  wire logic                     en_i,
    // intelligent input terminals and their function settings
    input  wire logic [N_TERM-1:0]        term_i,
    input  wire logic [N_TERM*FUNC_W-1:0] input_terminal_function_settings_i,
    // frequency configuration
    input  wire logic [7:0]               freq_src_i,
    input  wire logic [7:0]               analog_select_combination_i,
    // converted analog values and the non-analog command
    input  wire logic [ANA_W-1:0]         volt_input_i,
    input  wire logic [ANA_W-1:0]         current_input_i,
    input  wire logic [ANA_W-1:0]         pot_input_i,
    input  wire logic [ANA_W-1:0]         freq_other_i,
    // drive status
    input  wire logic                     run_cmd_i,
    input  wire logic                     trip_event_i,
    // frequency command
    output logic [ANA_W-1:0]              freq_cmd_o,
    output logic [1:0]                    freq_src_sel_o,
    // trip and reset
    output logic                          trip_o,
    output logic                          alarm_o,
    output logic                          motor_off_o,
    output logic                          powerup_reset_o,
    output logic                          restart_o,
    output logic                          motor_run_o
);

    // ------------------------------------------------------------
    // terminal function decode
    // ------------------------------------------------------------
    function automatic logic fn_func_active(
        input logic [N_TERM*FUNC_W-1:0] codes,
        input logic [N_TERM-1:0]        levels,
        input logic [7:0]               code
    );
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < N_TERM; i++) begin
            if (codes[i*FUNC_W +: FUNC_W] == code && levels[i]) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    wire sel_lvl;
    wire rs_lvl;

    assign sel_lvl = fn_func_active(input_terminal_function_settings_i, term_i,
                                    FUNC_ANALOG_SEL);
    assign rs_lvl  = fn_func_active(input_terminal_function_settings_i, term_i,
                                    FUNC_TRIP_RST);

    // ------------------------------------------------------------
    // analog source resolution
    // ------------------------------------------------------------
    ass_src_t         src_sel;
    wire              comb_vc;
    wire              comb_pc;
    wire              src_analog;
    logic [ANA_W-1:0] ana_val;
    wire [ANA_W-1:0]  nxt_freq;

    assign comb_vc    = (analog_select_combination_i == COMB_VOLT_CURR);
    assign comb_pc    = (analog_select_combination_i == COMB_POT_CURR);
    assign src_analog = (freq_src_i == FREQ_SRC_ANALOG);

    always_comb begin
        src_sel = SRC_VOLT;
        if (comb_vc) begin
            src_sel = sel_lvl ? SRC_VOLT : SRC_CURR;
        end else if (comb_pc) begin
            src_sel = sel_lvl ? SRC_POT : SRC_CURR;
        end else begin
            src_sel = sel_lvl ? SRC_POT : SRC_VOLT;
        end
    end

    always_comb begin
        ana_val = volt_input_i;
        case (src_sel)
            SRC_CURR: ana_val = current_input_i;
            SRC_POT:  ana_val = pot_input_i;
            default:  ana_val = volt_input_i;
        endcase
    end

    assign nxt_freq = src_analog ? ana_val : freq_other_i;

    logic [ANA_W-1:0] freq_ff;
    logic [1:0]       src_ff;

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            freq_ff <= FREQ_RST;
            src_ff  <= SRC_VOLT;
        end else if (en_i) begin
            freq_ff <= nxt_freq;
            src_ff  <= src_sel;
        end
    end

    // ------------------------------------------------------------
    // trip reset pulse qualification
    // ------------------------------------------------------------
    wire width_met;

    ass_pulse_width #(
        .MIN_CYC   (MIN_PULSE_CYC)
    ) u_width (
        .sys_clk_i (sys_clk_i),
        .rstn_i    (rstn_i),
        .en_i      (en_i),
        .level_i   (rs_lvl),
        .met_o     (width_met)
    );

    ass_rst_st_t st_ff;
    ass_rst_st_t nxt_st;
    logic        clear_now;
    logic        release_now;

    always_comb begin
        nxt_st      = st_ff;
        clear_now   = 1'b0;
        release_now = 1'b0;
        case (st_ff)
            ST_IDLE: begin
                if (rs_lvl) begin
                    nxt_st = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (!rs_lvl) begin
                    nxt_st = ST_IDLE;
                end else if (width_met) begin
                    nxt_st    = ST_ARMED;
                    clear_now = 1'b1;
                end
            end
            ST_ARMED: begin
                if (!rs_lvl) begin
                    nxt_st      = ST_IDLE;
                    release_now = 1'b1;
                end
            end
            default: nxt_st = ST_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // trip state and drive outputs
    // ------------------------------------------------------------
    logic trip_ff;
    logic alarm_ff;
    logic motor_off_ff;
    logic pwr_rst_ff;
    logic restart_ff;
    logic run_ff;
    wire  nxt_trip;
    wire  nxt_run;

    // a new trip in the clearing cycle wins
    assign nxt_trip = trip_event_i ? 1'b1 : (clear_now ? 1'b0 : trip_ff);
    // drive runs only with no trip and no reset held
    assign nxt_run  = run_cmd_i & ~nxt_trip & ~rs_lvl;

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_ff <= ST_IDLE;
        end else if (en_i) begin
            st_ff <= nxt_st;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            trip_ff  <= 1'b0;
            alarm_ff <= 1'b0;
        end else if (en_i) begin
            trip_ff  <= nxt_trip;
            alarm_ff <= nxt_trip;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            motor_off_ff <= 1'b0;
            pwr_rst_ff   <= 1'b0;
        end else if (en_i) begin
            motor_off_ff <= rs_lvl;
            pwr_rst_ff   <= release_now;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            restart_ff <= 1'b0;
            run_ff     <= 1'b0;
        end else if (en_i) begin
            restart_ff <= clear_now & trip_ff & ~trip_event_i & run_cmd_i;
            run_ff     <= nxt_run;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign freq_cmd_o      = freq_ff;
    assign freq_src_sel_o  = src_ff;
    assign trip_o          = trip_ff;
    assign alarm_o         = alarm_ff;
    assign motor_off_o     = motor_off_ff;
    assign powerup_reset_o = pwr_rst_ff;
    assign restart_o       = restart_ff;
    assign motor_run_o     = run_ff;

endmodule

// *** sim/ass_top_properties.sv ***
`timescale 1ns/1ps
module ass_top_checker
    import ass_pkg::*;
#(
    parameter int MIN_PULSE_CYC = RS_MIN_CYC
) (
    // clock and reset
    input wire logic             sys_clk_i,
    input wire logic             rstn_i,
    input wire logic             en_i,
    // inputs
    input wire logic [7:0]       freq_src_i,
    input wire logic [7:0]       analog_select_combination_i,
    input wire logic [ANA_W-1:0] volt_input_i,
    input wire logic [ANA_W-1:0] current_input_i,
    input wire logic [ANA_W-1:0] pot_input_i,
    input wire logic [ANA_W-1:0] freq_other_i,
    input wire logic             run_cmd_i,
    input wire logic             trip_event_i,
    // outputs
    input wire logic [ANA_W-1:0] freq_cmd_o,
    input wire logic [1:0]       freq_src_sel_o,
    input wire logic             trip_o,
    input wire logic             alarm_o,
    input wire logic             motor_off_o,
    input wire logic             powerup_reset_o,
    input wire logic             restart_o,
    input wire logic             motor_run_o
);
    // length of the current reset level, in enabled edges
    logic [31:0]      cnt_ff;
    wire logic [31:0] nxt_cnt = motor_off_o ? cnt_ff + 32'h1 : 32'h0;
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_ff <= 32'h0;
        end else if (en_i) begin
            cnt_ff <= nxt_cnt;
        end
    end
    // assertions wait one edge past reset release
    logic live_ff;
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            live_ff <= 1'b0;
        end else begin
            live_ff <= 1'b1;
        end
    end
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i || !live_ff);
    property p_path(ass_src_t s, logic [ANA_W-1:0] v);
        en_i && freq_src_i == FREQ_SRC_ANALOG |=> freq_src_sel_o != s || freq_cmd_o == $past(v);
    endproperty
    a_curr_path: assert property (p_path(SRC_CURR, current_input_i))
        else $error("current path wrong");
    a_volt_path: assert property (p_path(SRC_VOLT, volt_input_i))
        else $error("voltage path wrong");
    a_pot_path: assert property (p_path(SRC_POT, pot_input_i))
        else $error("pot path wrong");
    a_other_src: assert property (en_i && freq_src_i != FREQ_SRC_ANALOG |=>
        freq_cmd_o == $past(freq_other_i)) else $error("non-analog source wrong");
    a_comb_map: assert property (en_i |=> freq_src_sel_o !=
        ($past(analog_select_combination_i) == COMB_POT_CURR ? SRC_VOLT :
         $past(analog_select_combination_i) == COMB_VOLT_CURR ? SRC_POT : SRC_CURR))
        else $error("combination mapping wrong");
    a_clear_time: assert property (motor_off_o && cnt_ff == MIN_PULSE_CYC - 1 &&
        $past(cnt_ff) == MIN_PULSE_CYC - 2 && !$past(trip_event_i) |-> !alarm_o)
        else $error("alarm not cleared in time");
    a_pwrup_qual: assert property ($fell(motor_off_o) |->
        powerup_reset_o == (cnt_ff >= MIN_PULSE_CYC)) else $error("powerup reset wrong");
    a_motor_off: assert property (motor_off_o |-> !motor_run_o)
        else $error("motor runs during reset");
    a_restart: assert property (restart_o ==
        ($past(en_i) ? $fell(trip_o) && $past(run_cmd_i) : $past(restart_o)))
        else $error("restart wrong");
    c_clear: cover property ($fell(alarm_o));
    c_pwrup: cover property (powerup_reset_o);
    c_restart: cover property (restart_o);
endmodule

// *** sim/ass_ctrl_model.sv ***
`timescale 1ns/1ps
module ass_ctrl_model (
    // clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       rstn_i,
    // requests from the bench
    input  wire logic       sel_i,
    input  wire logic       pulse_i,
    input  wire logic [7:0] len_i,
    // terminal levels
    output logic [6:0]      term_o
);
    logic [7:0]      left_ff;
    wire logic [7:0] nxt_left = pulse_i ? len_i : left_ff - {7'h0, left_ff != 8'h0};
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            left_ff <= 8'h0;
        end else begin
            left_ff <= nxt_left;
        end
    end
    // terminal 0 resets trips, terminal 2 selects the source
    assign term_o = {4'h0, sel_i, 1'b0, left_ff != 8'h0};
endmodule

// *** sim/ass_top_tb.sv ***
`timescale 1ns/1ps
module ass_top_tb
    import ass_pkg::*;
();
    localparam int         MIN  = 6;
    localparam logic [9:0] VOLT = 10'h111;
    localparam logic [9:0] CURR = 10'h222;
    localparam logic [9:0] POT  = 10'h333;
    localparam logic [9:0] OTH  = 10'h044;
    logic             sys_clk_i = 1'b0;
    logic             rstn_i = 1'b0;
    logic             en_i = 1'b1;
    logic             sel = 1'b0;
    logic             pulse = 1'b0;
    logic             run_cmd_i = 1'b0;
    logic             trip_event_i = 1'b0;
    logic [7:0]       len = 8'h0;
    logic [7:0]       freq_src_i = 8'h0;
    logic [7:0]       analog_select_combination_i = 8'h0;
    logic [6:0]       term_i;
    logic [55:0]      input_terminal_function_settings_i =
                          {32'h0, FUNC_ANALOG_SEL, 8'h00, FUNC_TRIP_RST};
    logic [ANA_W-1:0] volt_input_i = VOLT;
    logic [ANA_W-1:0] current_input_i = CURR;
    logic [ANA_W-1:0] pot_input_i = POT;
    logic [ANA_W-1:0] freq_other_i = OTH;
    logic [ANA_W-1:0] freq_cmd_o;
    logic [1:0]       freq_src_sel_o;
    logic             trip_o, alarm_o, motor_off_o, powerup_reset_o, restart_o, motor_run_o;
    int               failures = 0;
    int               n_checks = 0;
    int               n_restart = 0;
    int               n_pwr = 0;
    always #2.5 sys_clk_i = ~sys_clk_i;
    ass_top #(.MIN_PULSE_CYC(MIN)) i_dut (.*);
    ass_ctrl_model i_ctrl (.sys_clk_i, .rstn_i, .sel_i(sel), .pulse_i(pulse), .len_i(len),
                           .term_o(term_i));
    always @(posedge sys_clk_i) begin
        if (restart_o === 1'b1) n_restart++;
        if (powerup_reset_o === 1'b1) n_pwr++;
    end
    // ----
    // shared tasks
    // ----
    task automatic check(input logic [9:0] seen, input logic [9:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask
    task automatic finish_test();
        if (failures == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // ----
    // scenarios
    // ----
    task automatic t_select();
        logic [7:0] cb [3] = '{8'h00, 8'h03, 8'h05};
        logic [9:0] exp_v;
        logic [1:0] exp_s;
        for (int c = 0; c < 3; c++) begin
            for (int a = 0; a < 2; a++) begin
                @(posedge sys_clk_i);
                analog_select_combination_i <= cb[c];
                sel <= a[0];
                freq_src_i <= FREQ_SRC_ANALOG;
                tick(2);
                exp_v = a ? (c == 0 ? VOLT : POT) : (c == 2 ? VOLT : CURR);
                exp_s = a ? (c == 0 ? SRC_VOLT : SRC_POT) : (c == 2 ? SRC_VOLT : SRC_CURR);
                check(freq_cmd_o, exp_v);
                check({8'h0, freq_src_sel_o}, {8'h0, exp_s});
            end
        end
        @(posedge sys_clk_i);
        freq_src_i <= 8'h00;
        tick(2);
        check(freq_cmd_o, OTH);
        @(posedge sys_clk_i);
        en_i <= 1'b0;
        freq_src_i <= FREQ_SRC_ANALOG;
        tick(3);
        check(freq_cmd_o, OTH);
        @(posedge sys_clk_i);
        en_i <= 1'b1;
    endtask
    task automatic t_reset(input logic [7:0] l, input logic run, input logic clr);
        @(posedge sys_clk_i);
        trip_event_i <= 1'b1;
        run_cmd_i <= run;
        @(posedge sys_clk_i);
        trip_event_i <= 1'b0;
        pulse <= 1'b1;
        len <= l;
        n_restart = 0;
        n_pwr = 0;
        @(posedge sys_clk_i);
        pulse <= 1'b0;
        tick(1);
        check({9'h0, motor_off_o}, 10'h001);
        check({9'h0, trip_o}, 10'h001);
        tick(l + 3);
        check({9'h0, alarm_o}, {9'h0, !clr});
        check({9'h0, trip_o}, {9'h0, !clr});
        check({9'h0, motor_off_o}, 10'h000);
        check(n_restart[9:0], {9'h0, run && clr});
        check(n_pwr[9:0], {9'h0, clr});
        check({9'h0, motor_run_o}, {9'h0, run && clr});
        @(posedge sys_clk_i);
        run_cmd_i <= 1'b0;
    endtask
    initial begin
        repeat (6) @(posedge sys_clk_i);
        rstn_i <= 1'b1;
        t_select();
        t_reset(8'h01, 1'b0, 1'b0);
        t_reset(8'(MIN - 1), 1'b1, 1'b0);
        t_reset(8'(MIN), 1'b0, 1'b1);
        t_reset(8'h28, 1'b1, 1'b1);
        finish_test();
    end
    initial begin
        #20000;
        failures++;
        finish_test();
    end
endmodule
bind ass_top ass_top_checker #(.MIN_PULSE_CYC(MIN_PULSE_CYC)) i_chk (.*);
